// ---- src/gpx_port.sv ----
// six-pin gpio port with external interrupts and axi4-lite registers
module gpx_port (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [5:0] pin_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   output logic [5:0] pin_pullup,
   input wire logic [5:0] alt_out_en,
   input wire logic [5:0] alt_out_val,
   input wire logic [5:0] alt_open_drain,
   input wire logic cpu_int_mask,
   input wire logic [3:0] vector_fetch,
   output logic [3:0] ext_irq
);
   localparam int N = gpx_pkg::GPX_PINS;
   localparam int S = gpx_pkg::GPX_SRCS;

   logic [N-1:0] data_reg, data_next;
   logic [N-1:0] dir_reg, dir_next;
   logic [N-1:0] opt_reg, opt_next;
   logic [2*S-1:0] sens_reg, sens_next;
   logic [N-1:0] s1_reg, s2_reg, s3_reg, stab_reg, stab_next;
   logic [N-1:0] out_reg, out_next, oe_reg, oe_next, pu_reg, pu_next;
   logic [S-1:0] irq_reg, irq_next;
   logic [S-1:0] sens_chg;
   logic [S-1:0] pend;
   logic [S-1:0] grp_level;
   logic [N-1:0] det_in;
   logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
   logic [7:0] aw_reg, aw_next;
   logic [31:0] wd_reg, wd_next;
   logic [3:0] ws_reg, ws_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic do_write;
   logic [4:0] wr_sel;
   // readies registered so every bus output leaves a flip-flop
   logic awready_reg, wready_reg, arready_reg;

   // map a bus offset onto a decoded register select
   function automatic logic [4:0] reg_sel(input logic [7:0] a);
      reg_sel = {a == gpx_pkg::GPX_OFS_PEND, a == gpx_pkg::GPX_OFS_SENS, a == gpx_pkg::GPX_OFS_OPT,
                 a == gpx_pkg::GPX_OFS_DIR, a == gpx_pkg::GPX_OFS_DATA};
   endfunction

   // which interrupt source a pin feeds
   function automatic logic [1:0] pin_src(input int p);
      pin_src = gpx_pkg::GPX_PIN_SRC[2*p +: 2];
   endfunction

   // ==============================
   // pin synchroniser, second and third stage must agree
   always_comb begin
      stab_next = stab_reg;
      for (int i = 0; i < N; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            stab_next[i] = s3_reg[i];
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s1_reg <= '1;
         s2_reg <= '1;
         s3_reg <= '1;
         stab_reg <= '1;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         stab_reg <= stab_next;
      end
   end

   // ==============================
   // pin drive: alternate output wins, then port direction
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (alt_out_en[i]) begin
            // peripheral chooses its own drive style
            out_next[i] = alt_out_val[i];
            oe_next[i] = alt_open_drain[i] ? !alt_out_val[i] : 1'b1;
            pu_next[i] = 1'b0;
         end else if (dir_reg[i] || i == gpx_pkg::GPX_RST_PIN) begin
            // latch value: zero always low, one high only in push-pull
            out_next[i] = data_reg[i];
            oe_next[i] = opt_reg[i] ? 1'b1 : !data_reg[i];
            pu_next[i] = 1'b0;
         end else begin
            // input: latch kept but not driven
            out_next[i] = 1'b0;
            oe_next[i] = 1'b0;
            pu_next[i] = opt_reg[i];
         end
      end
   end

   // ==============================
   // edge detector feed, held high when interrupt not selected
   always_comb begin
      for (int i = 0; i < N; i++) begin
         det_in[i] = (!dir_reg[i] && opt_reg[i] && i != gpx_pkg::GPX_RST_PIN) ? stab_reg[i] : 1'b1;
      end
      // and-combine each group so a low pin masks the rest
      grp_level = '1;
      for (int i = 0; i < N; i++) begin
         grp_level[pin_src(i)] = grp_level[pin_src(i)] & det_in[i];
      end
   end

   genvar g;
   generate
      for (g = 0; g < S; g++) begin : g_src
         gpx_edge u_edge (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .level(grp_level[g]),
            .sens(sens_reg[2*g +: 2]),
            .sens_change(sens_chg[g]),
            .vector_fetch(vector_fetch[g]),
            .pending(pend[g])
         );
      end
   endgenerate

   // request gated by the cpu mask
   always_comb begin
      irq_next = cpu_int_mask ? '0 : pend;
   end

   // ==============================
   // axi write channel: address and data taken in either order
   assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;
   assign wr_sel = reg_sel(aw_reg);
   always_comb begin
      aw_got_next = aw_got_reg;
      w_got_next = w_got_reg;
      aw_next = aw_reg;
      wd_next = wd_reg;
      ws_next = ws_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      data_next = data_reg;
      dir_next = dir_reg;
      opt_next = opt_reg;
      sens_next = sens_reg;
      sens_chg = '0;
      if (s_axi_awvalid && !aw_got_reg) begin
         aw_got_next = 1'b1;
         aw_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_reg) begin
         w_got_next = 1'b1;
         wd_next = s_axi_wdata;
         ws_next = s_axi_wstrb;
      end
      if (do_write) begin
         aw_got_next = 1'b0;
         w_got_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (reg_sel(aw_reg) != 5'h00) ? gpx_pkg::GPX_RESP_OKAY : gpx_pkg::GPX_RESP_SLVERR;
         // only byte lane 0 carries register bits
         if (ws_reg[0]) begin
            // each data, direction and option bit steers the pin at its own position
            if (wr_sel[0]) data_next = wd_reg[N-1:0];
            if (wr_sel[1]) dir_next = wd_reg[N-1:0];
            if (wr_sel[2]) opt_next = wd_reg[N-1:0];
            if (wr_sel[3]) begin
               sens_next = wd_reg[2*S-1:0];
               // per-pair compare, only a source whose code moved is cleared
               for (int k = 0; k < S; k++) begin
                  sens_chg[k] = wd_reg[2*k +: 2] != sens_reg[2*k +: 2];
               end
            end
         end
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_reg <= 8'h00;
         wd_reg <= 32'h0000_0000;
         ws_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= gpx_pkg::GPX_RESP_OKAY;
         data_reg <= gpx_pkg::GPX_RST_DATA[N-1:0];
         dir_reg <= gpx_pkg::GPX_RST_DIR[N-1:0];
         opt_reg <= gpx_pkg::GPX_RST_OPT[N-1:0];
         sens_reg <= gpx_pkg::GPX_RST_SENS[2*S-1:0];
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
      end else begin
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         aw_reg <= aw_next;
         wd_reg <= wd_next;
         ws_reg <= ws_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         data_reg <= data_next;
         dir_reg <= dir_next;
         opt_reg <= opt_next;
         sens_reg <= sens_next;
         awready_reg <= !aw_got_next;
         wready_reg <= !w_got_next;
      end
   end

   // ==============================
   // axi read channel, one cycle after the address is taken
   always_comb begin
      logic [N-1:0] rd_pins;
      rd_pins = '0;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      for (int i = 0; i < N; i++) begin
         if (alt_out_en[i]) begin
            rd_pins[i] = alt_out_val[i];
         end else if (dir_reg[i] || i == gpx_pkg::GPX_RST_PIN) begin
            rd_pins[i] = data_reg[i];
         end else begin
            rd_pins[i] = stab_reg[i];
         end
      end
      if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rresp_next = gpx_pkg::GPX_RESP_OKAY;
         case (reg_sel(s_axi_araddr))
            5'h01: rdata_next = {26'h0, rd_pins};
            5'h02: rdata_next = {26'h0, dir_reg};
            5'h04: rdata_next = {26'h0, opt_reg};
            5'h08: rdata_next = {24'h0, sens_reg};
            5'h10: rdata_next = {28'h0, pend};
            default: begin
               rdata_next = 32'h0000_0000;
               rresp_next = gpx_pkg::GPX_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= gpx_pkg::GPX_RESP_OKAY;
         out_reg <= '0;
         oe_reg <= '0;
         pu_reg <= '0;
         irq_reg <= '0;
         arready_reg <= 1'b1;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         out_reg <= out_next;
         oe_reg <= oe_next;
         pu_reg <= pu_next;
         irq_reg <= irq_next;
         arready_reg <= !rvalid_next;
      end
   end

   // ==============================
   // outputs straight from flip-flops
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign pin_out = out_reg;
   assign pin_oe = oe_reg;
   assign pin_pullup = pu_reg;
   assign ext_irq = irq_reg;
endmodule

// ---- src/gpx_pkg.sv ----
// package with register map, field layout and reset values of the six-pin port
// ==============================
// How it works
// - direction clear: pin is input, data read returns the synchronised pin level
// - bit x of data, direction and option registers controls pin x
// - writing data of an input pin only updates the latch, pin untouched
// - the reset-shared pin is never an input, outputs only
// - each interrupt input pin raises a request; sensitivity per source in control register
// - interrupt pins of one vector group are combined, low pin masks others
// - pending request clears when the cpu fetches the matching vector
// - changing a source's sensitivity clears its pending request
// - option clear forces edge detector input to one; toggling may give spurious edge
// - direction set: pin driven from latch, data read returns latch value
// - output option: one push-pull, zero open-drain; latch zero always drives low
// - alternate output overrides port settings, forcing output in its own drive mode
// - input option bit selects floating or pull-up with interrupt
// - interrupt only when input-with-interrupt selected and cpu mask is clear
// - input pin driven by alternate output reads back the alternate output
package gpx_pkg;
   localparam int GPX_PINS = 6;
   localparam int GPX_SRCS = 4;
   // reset-shared output-only pin
   localparam int GPX_RST_PIN = 3;
   // byte offsets on the register bus
   localparam logic [7:0] GPX_OFS_DATA = 8'h00;
   localparam logic [7:0] GPX_OFS_DIR = 8'h04;
   localparam logic [7:0] GPX_OFS_OPT = 8'h08;
   localparam logic [7:0] GPX_OFS_SENS = 8'h0c;
   localparam logic [7:0] GPX_OFS_PEND = 8'h10;
   // reset values
   localparam logic [7:0] GPX_RST_DATA = 8'h00;
   localparam logic [7:0] GPX_RST_DIR = 8'h08;
   localparam logic [7:0] GPX_RST_OPT = 8'h02;
   localparam logic [7:0] GPX_RST_SENS = 8'h00;
   // sensitivity codes, two bits per source
   localparam logic [1:0] GPX_SENS_FALL_LOW = 2'h0;
   localparam logic [1:0] GPX_SENS_RISE = 2'h1;
   localparam logic [1:0] GPX_SENS_FALL = 2'h2;
   localparam logic [1:0] GPX_SENS_BOTH = 2'h3;
   // axi responses
   localparam logic [1:0] GPX_RESP_OKAY = 2'h0;
   localparam logic [1:0] GPX_RESP_SLVERR = 2'h2;
   // pin to interrupt source grouping, 2 bits per pin
   localparam logic [11:0] GPX_PIN_SRC = 12'hed0;
endpackage

// ---- src/gpx_edge.sv ----
// per-source sensitivity detector with pending latch
module gpx_edge (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic level,
   input wire logic [1:0] sens,
   input wire logic sens_change,
   input wire logic vector_fetch,
   output logic pending
);
   logic prev_reg, prev_next;
   logic pend_reg, pend_next;
   logic hit;
   assign pending = pend_reg;
   // ==============================
   // event detect
   always_comb begin
      prev_next = level;
      case (sens)
         gpx_pkg::GPX_SENS_FALL_LOW: hit = !level;
         gpx_pkg::GPX_SENS_RISE: hit = level && !prev_reg;
         gpx_pkg::GPX_SENS_FALL: hit = !level && prev_reg;
         default: hit = level != prev_reg;
      endcase
      // fetch and sensitivity change clear; fresh event wins over fetch
      pend_next = pend_reg;
      if (vector_fetch) begin
         pend_next = 1'b0;
      end
      if (hit) begin
         pend_next = 1'b1;
      end
      if (sens_change) begin
         pend_next = 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         prev_reg <= 1'b1;
         pend_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
         pend_reg <= pend_next;
      end
   end
endmodule

// ---- verification/gpx_port_properties.sv ----
// concurrent checks on the port's bus handshakes, pin drive and interrupt outputs
module gpx_port_chk (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] pin_pullup,
   input wire logic [5:0] alt_out_en,
   input wire logic [5:0] alt_out_val,
   input wire logic [5:0] alt_open_drain,
   input wire logic cpu_int_mask,
   input wire logic [3:0] ext_irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // ==============================
   // alternate drive on pin 0, held two cycles so the output register has caught up
   sequence s_alt_pp;
      (alt_out_en[0] && !alt_open_drain[0] && alt_out_val[0]) [*2];
   endsequence
   sequence s_alt_od;
      (alt_out_en[0] && alt_open_drain[0] && alt_out_val[0]) [*2];
   endsequence
   // ==============================
   // bus answers and pin rules
   chk_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("write address accepted twice");
   chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_irq_unmasked: assert property (ext_irq != 4'h0 |-> !$past(cpu_int_mask))
      else $error("request while masked");
   chk_rst_pin_out: assert property (!pin_pullup[3])
      else $error("reset-shared pin in input mode");
   chk_alt_push: assert property (s_alt_pp |-> pin_oe[0] && pin_out[0])
      else $error("alternate push-pull not driven");
   chk_alt_drain: assert property (s_alt_od |-> !pin_oe[0])
      else $error("alternate open-drain high driven");
endmodule
bind gpx_port gpx_port_chk chk_u (.ref_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pin_out, .pin_oe, .pin_pullup,
   .alt_out_en, .alt_out_val, .alt_open_drain, .cpu_int_mask, .ext_irq);

// ---- verification/gpx_pin_model.sv ----
// board side of the six pins: external drivers, pull-ups and floating lines
module gpx_pin_model (
   input wire logic ref_clk,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] pin_pullup,
   input wire logic [5:0] ext_en,
   input wire logic [5:0] ext_drv,
   output logic [5:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] float_reg = 6'h00;
   // an undriven line wanders, so no reader can lean on a remembered level
   always_ff @(posedge ref_clk) begin
      float_reg <= ~pin_in;
   end
   // port drive wins, then the board, then the pull-up
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         if (pin_oe[k])
            pin_in[k] = pin_out[k];
         else if (ext_en[k])
            pin_in[k] = ext_drv[k];
         else if (pin_pullup[k])
            pin_in[k] = 1'h1;
         else
            pin_in[k] = float_reg[k];
      end
   end
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the six-pin port with external interrupts
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic rstn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cpu_int_mask = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, vector_fetch = 4'h0, ext_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [5:0] pin_in, pin_out, pin_oe, pin_pullup;
   logic [5:0] alt_out_en = 6'h00, alt_out_val = 6'h00, alt_open_drain = 6'h00;
   logic [5:0] ext_en = 6'h37, ext_drv = 6'h02;
   int n_fail = 0, compares = 0;
   gpx_port dut_u (.*);
   gpx_pin_model pm_u (.*);
   initial begin
      ref_clk = 1'h0;
      forever #10 ref_clk = ~ref_clk;
   end
   // ==============================
   // checking and closing
   task automatic tally_and_finish();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic guard(input int n);
      if (n > 40) begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge ref_clk);
   endtask
   // ==============================
   // bus master: readies are registered, so a negedge look predicts the next edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw, w, b;
      int n;
      b = 1'h0;
      n = 0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!b) begin
         @(negedge ref_clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         if (b)
            chk({30'h0, s_axi_bresp}, {30'h0, er});
         @(posedge ref_clk);
         if (aw)
            s_axi_awvalid <= 1'h0;
         if (w)
            s_axi_wvalid <= 1'h0;
         if (b)
            s_axi_bready <= 1'h0;
         n++;
         guard(n);
      end
   endtask
   // bits above the low byte must read zero; low-byte bits outside the mask are not compared
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input logic [1:0] er);
      logic ar, r;
      int n;
      r = 1'h0;
      n = 0;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!r) begin
         @(negedge ref_clk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         if (r) begin
            chk(s_axi_rdata & {24'hffffff, m}, {24'h0, e & m});
            chk({30'h0, s_axi_rresp}, {30'h0, er});
         end
         @(posedge ref_clk);
         if (ar)
            s_axi_arvalid <= 1'h0;
         if (r)
            s_axi_rready <= 1'h0;
         n++;
         guard(n);
      end
   endtask
   task automatic wait_irq(input int k, input logic v);
      int n;
      n = 0;
      while (ext_irq[k] !== v) begin
         @(negedge ref_clk);
         n++;
         guard(n);
      end
      chk({31'h0, ext_irq[k]}, {31'h0, v});
   endtask
   // ==============================
   // scenarios
   initial begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'h1;
      rd(8'h04, 8'h08, 8'hff, 2'h0);
      rd(8'h08, 8'h02, 8'hff, 2'h0);
      rd(8'h0c, 8'h00, 8'hff, 2'h0);
      rd(8'h14, 8'h00, 8'hff, 2'h2);
      wr(8'h14, 8'hff, 2'h2);
      rd(8'h04, 8'h08, 8'hff, 2'h0);
      chk({26'h0, pin_pullup}, 32'h02);
      ext_drv <= 6'h15;
      tick(10);
      rd(8'h00, 8'h15, 8'hff, 2'h0);
      ext_drv <= 6'h22;
      wr(8'h00, 8'h01, 2'h0);
      tick(10);
      chk({26'h0, pin_oe}, 32'h08);
      rd(8'h00, 8'h22, 8'hff, 2'h0);
      wr(8'h08, 8'h03, 2'h0);
      wr(8'h04, 8'h09, 2'h0);
      tick(2);
      chk({20'h0, pin_oe, pin_out & 6'h09}, 32'h241);
      wr(8'h08, 8'h02, 2'h0);
      tick(2);
      chk({26'h0, pin_oe}, 32'h08);
      rd(8'h00, 8'h23, 8'hff, 2'h0);
      wr(8'h00, 8'h00, 2'h0);
      tick(2);
      chk({20'h0, pin_oe, pin_out & 6'h09}, 32'h240);
      wr(8'h04, 8'h00, 2'h0);
      wr(8'h08, 8'h0a, 2'h0);
      tick(2);
      chk({20'h0, pin_oe, pin_pullup}, 32'h202);
      wr(8'h08, 8'h02, 2'h0);
      @(posedge ref_clk);
      alt_out_val <= 6'h01;
      alt_out_en <= 6'h01;
      tick(3);
      chk({26'h0, pin_oe}, 32'h09);
      rd(8'h00, 8'h23, 8'hff, 2'h0);
      alt_open_drain <= 6'h01;
      tick(3);
      chk({26'h0, pin_oe}, 32'h08);
      @(posedge ref_clk);
      alt_out_en <= 6'h00;
      cpu_int_mask <= 1'h1;
      wr(8'h0c, 8'h10, 2'h0);
      wr(8'h08, 8'h12, 2'h0);
      @(posedge ref_clk);
      cpu_int_mask <= 1'h0;
      ext_drv <= 6'h32;
      wait_irq(2, 1'h1);
      rd(8'h10, 8'h04, 8'h04, 2'h0);
      @(posedge ref_clk);
      vector_fetch <= 4'h4;
      @(posedge ref_clk);
      vector_fetch <= 4'h0;
      wait_irq(2, 1'h0);
      rd(8'h10, 8'h00, 8'h04, 2'h0);
      @(posedge ref_clk);
      cpu_int_mask <= 1'h1;
      ext_drv <= 6'h22;
      tick(10);
      @(posedge ref_clk);
      ext_drv <= 6'h32;
      tick(10);
      chk({28'h0, ext_irq}, 32'h0);
      rd(8'h10, 8'h04, 8'h04, 2'h0);
      wr(8'h0c, 8'h20, 2'h0);
      rd(8'h10, 8'h00, 8'h04, 2'h0);
      wr(8'h08, 8'h02, 2'h0);
      wr(8'h0c, 8'h10, 2'h0);
      ext_drv <= 6'h02;
      cpu_int_mask <= 1'h0;
      wr(8'h0c, 8'h80, 2'h0);
      wr(8'h08, 8'h22, 2'h0);
      tick(10);
      rd(8'h10, 8'h08, 8'h08, 2'h0);
      ext_drv <= 6'h00;
      wr(8'h08, 8'h03, 2'h0);
      tick(10);
      wr(8'h0c, 8'h81, 2'h0);
      ext_drv <= 6'h01;
      tick(10);
      rd(8'h10, 8'h00, 8'h01, 2'h0);
      ext_drv <= 6'h03;
      tick(10);
      rd(8'h10, 8'h01, 8'h01, 2'h0);
      // both-edge code: a falling group level must also set the request
      wr(8'h0c, 8'h83, 2'h0);
      rd(8'h10, 8'h00, 8'h01, 2'h0);
      ext_drv <= 6'h01;
      tick(10);
      rd(8'h10, 8'h01, 8'h01, 2'h0);
      tally_and_finish();
   end
endmodule
